//--- hw/lca_cluster.sv
// Overview of operation
// - carry chain starts at first or fifth cell
// - long carry chains continue into next cluster
// - half chains feed same half next cluster
// - column type selects upper or lower bypass
// - final carry-out returned as ordinary output
// - shared mode uses four three-operand tables
// - shared carry goes to next adder
// - shared chain starts at first or sixth
// - long shared chains continue down the column
// - shared chains bypass half per column type
// - tables form master and slave latch
// - table register shares upper register controls
// - register cascade links cells directly
// - tables stay free during register cascade
// - at most two clear signals per cluster
// - global clear resets all, highest priority
// - preset only by inverting around clear
// - unused adders have inputs held low
// - each cluster clock paired with its enable
// - shared gated clock instead per-register enable
// - two-bit carry select inside each cell
// - carry in, first adder, second adder, next
`timescale 1ns/1ns
`default_nettype none
module lca_cluster #(
    parameter logic BYPASS_TOP = lca_pkg::BYPASS_TOP_DEFAULT
) (
    input  wire logic        i_clock,                   // 10 MHz clock
    input  wire logic        i_rst_b,                   // async reset
    input  wire logic        i_global_clear_n,          // device clear
    input  wire logic        i_global_clear_en,         // clear option
    input  wire logic [1:0]  i_clear_n,                 // cluster clears
    input  wire logic        i_cluster_clock_one,       // clock one tick
    input  wire logic        i_cluster_clock_enable_one, // enable one
    input  wire logic        i_cluster_clock_two,       // clock two tick
    input  wire logic        i_cluster_clock_enable_two, // enable two
    input  wire lca_pkg::lca_cfg_t i_cfg,               // chain setup
    input  wire lca_pkg::lca_mode_t [9:0] i_mode,       // cell modes
    input  wire lca_pkg::lca_ops_t  [9:0] i_ops,        // cell operands
    input  wire logic [15:0] i_lut_mask,                // comb table
    input  wire logic [9:0]  i_preset,                  // preset per cell
    input  wire logic [9:0]  i_clear_sel,               // clear choice
    input  wire logic        i_carry_in_upper,          // carry in top
    input  wire logic        i_carry_in_lower,          // carry in lower
    input  wire logic        i_shared_in_upper,         // shared in top
    input  wire logic        i_shared_in_lower,         // shared in lower
    input  wire logic        i_reg_chain_in,            // cascade in
    output logic             o_carry_out_upper,         // carry out top
    output logic             o_carry_out_lower,         // carry out lower
    output logic             o_shared_out_upper,        // shared out top
    output logic             o_shared_out_lower,        // shared out low
    output logic             o_final_carry,             // chain end carry
    output logic             o_reg_chain_out,           // cascade out
    output logic [9:0]       o_upper_q,                 // upper registers
    output logic [9:0]       o_lower_q,                 // lower registers
    output logic [9:0]       o_comb,                    // comb outputs
    output logic [9:0]       o_lut_reg_q                // table registers
);

    localparam int NC = lca_pkg::NUM_CELLS;
    localparam int UL = lca_pkg::UPPER_LAST;
    localparam int LF = lca_pkg::LOWER_FIRST;
    localparam int LC = lca_pkg::LAST_CELL;

    lca_pkg::lca_state_t state_reg;
    lca_pkg::lca_state_t state_next;

    logic [NC-1:0] cin;
    logic [NC-1:0] cout;
    logic [NC-1:0] sin;
    logic [NC-1:0] sout;
    logic [NC-1:0] cell_comb;
    logic [NC-1:0] clr;
    logic [1:0]    sum [NC];
    logic          tick_one;
    logic          tick_two;
    logic          global_clr;
    logic          byp_up_c;
    logic          byp_lo_c;
    logic          byp_up_s;
    logic          byp_lo_s;

    // ==========================================================
    // cluster controls
    // one gated tick per clock, shared by every register on it
    assign tick_one   = i_cluster_clock_one &
                        i_cluster_clock_enable_one;
    assign tick_two   = i_cluster_clock_two &
                        i_cluster_clock_enable_two;
    assign global_clr = i_global_clear_en & ~i_global_clear_n;
    assign byp_up_c = i_cfg.carry_split & i_cfg.carry_bypass &
                      BYPASS_TOP;
    assign byp_lo_c = i_cfg.carry_split & i_cfg.carry_bypass &
                      ~BYPASS_TOP;
    assign byp_up_s = i_cfg.shared_split & i_cfg.shared_bypass &
                      BYPASS_TOP;
    assign byp_lo_s = i_cfg.shared_split & i_cfg.shared_bypass &
                      ~BYPASS_TOP;

    // ==========================================================
    // cells and chain wiring, index 0 is the top cell
    for (genvar i = 0; i < NC; i++) begin : g_cell
        // each cell picks one of the two cluster clears
        assign clr[i] = ~i_clear_n[i_clear_sel[i]];
        if (i == lca_pkg::CARRY_ORIGIN_A) begin : g_c0
            assign cin[i] = i_cfg.carry_start_first ? 1'b0 :
                            i_carry_in_upper;
        end else if (i == lca_pkg::CARRY_ORIGIN_B) begin : g_c4
            assign cin[i] = i_cfg.carry_start_fifth ? 1'b0 :
                            cout[i-1];
        end else if (i == LF) begin : g_c5
            assign cin[i] = i_cfg.carry_split ? i_carry_in_lower :
                            cout[i-1];
        end else begin : g_cn
            assign cin[i] = cout[i-1];
        end
        if (i == lca_pkg::SHARED_ORIGIN_A) begin : g_s0
            assign sin[i] = i_cfg.shared_start_first ? 1'b0 :
                            i_shared_in_upper;
        end else if (i == lca_pkg::SHARED_ORIGIN_B) begin : g_s5
            assign sin[i] = i_cfg.shared_start_sixth ? 1'b0 :
                            i_cfg.shared_split ? i_shared_in_lower :
                            sout[i-1];
        end else begin : g_sn
            assign sin[i] = sout[i-1];
        end
        lca_cell u_cell (
            .i_mode       (i_mode[i]),
            .i_ops        (i_ops[i]),
            .i_lut_mask   (i_lut_mask),
            .i_carry_in   (cin[i]),
            .i_shared_in  (sin[i]),
            .o_sum        (sum[i]),
            .o_carry_out  (cout[i]),
            .o_shared_out (sout[i]),
            .o_comb       (cell_comb[i])
        );
    end

    // ==========================================================
    // next state
    always_comb begin
        state_next = state_reg;
        for (int i = 0; i < NC; i++) begin
            // comb path runs regardless of the cascade
            state_next.comb_q[i] = cell_comb[i];
            if (clr[i]) begin
                // clear shows the preset polarity
                state_next.upper_q[i]    = i_preset[i];
                state_next.lower_q[i]    = i_preset[i];
                state_next.lut_master[i] = 1'b0;
                state_next.lut_slave[i]  = 1'b0;
            end else begin
                if (tick_one) begin
                    if (i_cfg.reg_chain_en) begin
                        state_next.upper_q[i] = (i == 0) ?
                            i_reg_chain_in :
                            state_reg.upper_q[(i+NC-1)%NC];
                    end else begin
                        state_next.upper_q[i] = sum[i][0];
                    end
                    if (i_cfg.lut_reg_en) begin
                        // first table captures, second table takes the same new value in the same tick
                        state_next.lut_master[i] = cell_comb[i];
                        state_next.lut_slave[i]  =
                            state_next.lut_master[i];
                    end
                end
                if (tick_two) begin
                    state_next.lower_q[i] = sum[i][1];
                end
            end
        end
        if (tick_one) begin
            // unsplit chain leaves from last cell to next cluster top
            state_next.carry_up = !i_cfg.carry_split ? cout[LC] :
                byp_up_c ? i_carry_in_upper : cout[UL];
            state_next.carry_lo = !i_cfg.carry_split ? 1'b0 :
                byp_lo_c ? i_carry_in_lower : cout[LC];
            state_next.shared_up = !i_cfg.shared_split ? sout[LC] :
                byp_up_s ? i_shared_in_upper : sout[UL];
            state_next.shared_lo = !i_cfg.shared_split ? 1'b0 :
                byp_lo_s ? i_shared_in_lower : sout[LC];
            state_next.final_carry = (i_cfg.carry_split && byp_lo_c) ?
                cout[UL] : cout[LC];
        end
        if (global_clr) begin
            // overrides every clear, enable and data input
            state_next = '0;
            state_next.upper_q = i_preset;
            state_next.lower_q = i_preset;
        end
    end

    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ==========================================================
    // outputs
    assign o_carry_out_upper  = state_reg.carry_up;
    assign o_carry_out_lower  = state_reg.carry_lo;
    assign o_shared_out_upper = state_reg.shared_up;
    assign o_shared_out_lower = state_reg.shared_lo;
    assign o_final_carry      = state_reg.final_carry;
    assign o_reg_chain_out    = state_reg.upper_q[LC];
    assign o_upper_q          = state_reg.upper_q;
    assign o_lower_q          = state_reg.lower_q;
    assign o_comb             = state_reg.comb_q;
    assign o_lut_reg_q        = state_reg.lut_slave;

    // ==========================================================
    // checks
    property p_carry_origin;
        @(posedge i_clock) disable iff (!i_rst_b)
        (cin[1] == cout[0]) && (cin[2] == cout[1]) &&
        (cin[4] == (i_cfg.carry_start_fifth ? 1'b0 : cout[3]));
    endproperty
    a_carry_origin: assert property (p_carry_origin)
        else $error("carry chain origin at an illegal cell");

    property p_shared_origin;
        @(posedge i_clock) disable iff (!i_rst_b)
        i_cfg.shared_start_sixth |-> (sin[5] == 1'b0) &&
        (sin[6] == sout[5]);
    endproperty
    a_shared_origin: assert property (p_shared_origin)
        else $error("shared chain origin at an illegal cell");

    property p_half_link;
        @(posedge i_clock) disable iff (!i_rst_b)
        (tick_one && !global_clr && i_cfg.carry_split && !byp_lo_c)
        |=> (o_carry_out_lower == $past(cout[9]));
    endproperty
    a_half_link: assert property (p_half_link)
        else $error("lower half carry not passed to next cluster");

    property p_bypass;
        @(posedge i_clock) disable iff (!i_rst_b)
        (tick_one && !global_clr && byp_up_c)
        |=> (o_carry_out_upper == $past(i_carry_in_upper)) &&
            (BYPASS_TOP == 1'b1);
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("upper half bypass wrong or in wrong column");

    property p_global_clear;
        @(posedge i_clock) disable iff (!i_rst_b)
        global_clr |=> (o_upper_q == $past(i_preset)) &&
            (o_lut_reg_q == 10'h000) && (o_final_carry == 1'b0);
    endproperty
    a_global_clear: assert property (p_global_clear)
        else $error("global clear did not reset the registers");

    property p_cascade;
        @(posedge i_clock) disable iff (!i_rst_b)
        (tick_one && i_cfg.reg_chain_en && !global_clr && (clr == 10'h000))
        |=> (o_upper_q == {$past(o_upper_q[8:0]), $past(i_reg_chain_in)});
    endproperty
    a_cascade: assert property (p_cascade)
        else $error("register cascade did not shift");

    property p_gated_hold;
        @(posedge i_clock) disable iff (!i_rst_b)
        (!tick_one && !global_clr && (clr == 10'h000))
        |=> $stable(o_upper_q) && $stable(o_lut_reg_q);
    endproperty
    a_gated_hold: assert property (p_gated_hold)
        else $error("register changed without its gated clock");

    property p_lut_reg;
        @(posedge i_clock) disable iff (!i_rst_b)
        (tick_one && i_cfg.lut_reg_en && !global_clr && (clr == 10'h000))
        |=> (o_lut_reg_q == $past(cell_comb));
    endproperty
    a_lut_reg: assert property (p_lut_reg)
        else $error("table register missed the upper clock");

    property p_unused_adder;
        @(posedge i_clock) disable iff (!i_rst_b)
        (i_mode[2] == lca_pkg::LCA_MODE_OFF) |->
            (sum[2] == 2'h0) && (cout[2] == 1'b0) && (sout[2] == 1'b0);
    endproperty
    a_unused_adder: assert property (p_unused_adder)
        else $error("unused adder is toggling");

    property p_preset_clear;
        @(posedge i_clock) disable iff (!i_rst_b)
        (clr[3] && !global_clr) |=>
            (o_upper_q[3] == $past(i_preset[3])) &&
            (o_lower_q[3] == $past(i_preset[3]));
    endproperty
    a_preset_clear: assert property (p_preset_clear)
        else $error("clear did not show preset polarity");

endmodule : lca_cluster
`default_nettype wire

//--- hw/lca_pkg.sv
`default_nettype none
package lca_pkg;

    // ==========================================================
    // cluster geometry, cells indexed from the top
    localparam int NUM_CELLS        = 10;
    localparam int HALF_CELLS       = 5;
    localparam int CELL_BITS        = 2;
    localparam int NUM_CLEARS       = 2;
    localparam int LUT_MASK_W       = 16;

    // ==========================================================
    // chain origins and half boundaries
    localparam int CARRY_ORIGIN_A   = 0;
    localparam int CARRY_ORIGIN_B   = 4;
    localparam int SHARED_ORIGIN_A  = 0;
    localparam int SHARED_ORIGIN_B  = 5;
    localparam int UPPER_LAST       = HALF_CELLS - 1;
    localparam int LOWER_FIRST      = HALF_CELLS;
    localparam int LAST_CELL        = NUM_CELLS - 1;

    // ==========================================================
    // reset values and column type
    localparam logic       BYPASS_TOP_DEFAULT = 1'b1;
    localparam logic [9:0] CELL_RESET         = 10'h000;

    // ==========================================================
    // cell configurations
    typedef enum logic [1:0] {
        LCA_MODE_OFF,
        LCA_MODE_ARITH,
        LCA_MODE_SHARED,
        LCA_MODE_NORMAL
    } lca_mode_t;

    // three operand bits per adder position
    typedef struct packed {
        logic [CELL_BITS-1:0] x;
        logic [CELL_BITS-1:0] y;
        logic [CELL_BITS-1:0] z;
    } lca_ops_t;

    // cluster wide chain configuration
    typedef struct packed {
        logic carry_split;
        logic carry_start_first;
        logic carry_start_fifth;
        logic carry_bypass;
        logic shared_split;
        logic shared_start_first;
        logic shared_start_sixth;
        logic shared_bypass;
        logic reg_chain_en;
        logic lut_reg_en;
    } lca_cfg_t;

    // whole state of the cluster
    typedef struct packed {
        logic [NUM_CELLS-1:0] upper_q;
        logic [NUM_CELLS-1:0] lower_q;
        logic [NUM_CELLS-1:0] lut_master;
        logic [NUM_CELLS-1:0] lut_slave;
        logic [NUM_CELLS-1:0] comb_q;
        logic                 carry_up;
        logic                 carry_lo;
        logic                 shared_up;
        logic                 shared_lo;
        logic                 final_carry;
    } lca_state_t;

endpackage : lca_pkg
`default_nettype wire

//--- hw/lca_cell.sv
`timescale 1ns/1ns
`default_nettype none
module lca_cell (
    input  wire lca_pkg::lca_mode_t i_mode,       // cell configuration
    input  wire lca_pkg::lca_ops_t  i_ops,        // operand bits
    input  wire logic [15:0]        i_lut_mask,   // comb truth table
    input  wire logic               i_carry_in,   // carry from above
    input  wire logic               i_shared_in,  // shared chain in
    output logic [1:0]              o_sum,        // two adder sums
    output logic                    o_carry_out,  // carry to below
    output logic                    o_shared_out, // shared chain out
    output logic                    o_comb        // unrelated comb out
);

    logic [1:0] sum_lut;
    logic [1:0] car_lut;
    logic [1:0] add_a;
    logic [1:0] add_b;
    logic [1:0] gen;
    logic [1:0] prop;
    logic       cin;
    logic       active;
    logic       shared;
    logic       c_mid;
    logic       c_if0;
    logic       c_if1;

    // ==========================================================
    // adders and carry select
    always_comb begin
        active = (i_mode == lca_pkg::LCA_MODE_ARITH) ||
                 (i_mode == lca_pkg::LCA_MODE_SHARED);
        shared = (i_mode == lca_pkg::LCA_MODE_SHARED);
        // four tables: sum and carry of three operands per bit
        sum_lut = i_ops.x ^ i_ops.y ^ i_ops.z;
        car_lut = (i_ops.x & i_ops.y) | (i_ops.x & i_ops.z) |
                  (i_ops.y & i_ops.z);
        if (shared) begin
            add_a = sum_lut;
            // bit0 carry term goes to second adder
            add_b = {car_lut[0], i_shared_in};
        end else begin
            add_a = i_ops.x;
            add_b = i_ops.y;
        end
        cin = i_carry_in;
        if (!active) begin
            add_a = 2'h0;
            add_b = 2'h0;
            cin   = 1'b0;
        end
        gen   = add_a & add_b;
        prop  = add_a ^ add_b;
        // first adder carry feeds second adder
        c_mid = gen[0] | (prop[0] & cin);
        o_sum = {prop[1] ^ c_mid, prop[0] ^ cin};
        // both outcomes ready, one select on carry in
        c_if0 = gen[1] | (prop[1] & gen[0]);
        c_if1 = gen[1] | (prop[1] & (gen[0] | prop[0]));
        o_carry_out  = cin ? c_if1 : c_if0;
        // bit1 carry term goes to next cell
        o_shared_out = (active && shared) ? car_lut[1] : 1'b0;
        o_comb = i_lut_mask[{i_ops.x[1], i_ops.y[1],
                             i_ops.x[0], i_ops.y[0]}];
    end

endmodule : lca_cell
`default_nettype wire

//--- verification/lca_nbr.sv
`timescale 1ns/1ns
`default_nettype none
module lca_nbr (
    input  wire logic       i_clock,  // system clock
    input  wire logic       i_rst_b,  // async reset
    input  wire logic       i_load,   // take new link values
    input  wire logic [3:0] i_links,  // carry up/lo, shared up/lo
    output logic      [3:0] o_links   // registered chain links
);
    // ==========================================================
    // neighbour above: its link outputs are registered
    logic [3:0] links_reg;
    logic [3:0] links_next;
    always_comb begin
        links_next = i_load ? i_links : links_reg;
    end
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            links_reg <= 4'h0;
        end else begin
            links_reg <= links_next;
        end
    end
    assign o_links = links_reg;
endmodule : lca_nbr
`default_nettype wire

//--- verification/lca_cluster_tb.sv
`timescale 1ns/1ns
`default_nettype none
module lca_cluster_tb;
    // ==========================================================
    // signals
    localparam logic BT = 1'b1;
    typedef struct packed {
        logic [9:0] up;
        logic [9:0] lo;
        logic [4:0] lk;
    } lca_exp_t;
    typedef struct packed {
        lca_pkg::lca_mode_t m;
        logic [9:0]         g;
        logic [3:0]         li;
        lca_exp_t           e;
    } lca_row_t;
    logic                     clk = 1'b0;
    logic                     rst_b = 1'b0;
    logic                     gcl_n = 1'b1;
    logic                     gce = 1'b0;
    logic [1:0]               clr_n = 2'b11;
    logic [3:0]               tk = 4'h0;
    logic [9:0]               cfg = 10'h000;
    lca_pkg::lca_mode_t [9:0] mode;
    lca_pkg::lca_ops_t  [9:0] ops = '0;
    logic [15:0]              mask = 16'h6ac5;
    logic [9:0]               pre = 10'h0c0;
    logic [9:0]               csel = 10'h0f0;
    logic                     rin = 1'b0;
    logic                     load = 1'b0;
    logic [3:0]               nin = 4'h0;
    wire  logic [3:0]         nl;
    wire  logic [4:0]         lk;
    wire  logic               cho;
    wire  logic [9:0]         up, lo, comb, lutq;
    logic [9:0]               sh, lo_e, cx, sm;
    int                       err_count = 0;
    int                       check_count = 0;
    int                       cycles = 0;
    lca_row_t                 rows[$];

    lca_nbr NBR (.i_clock(clk), .i_rst_b(rst_b), .i_load(load),
                 .i_links(nin), .o_links(nl));
    lca_cluster #(.BYPASS_TOP(BT)) DUT (
        .i_clock(clk), .i_rst_b(rst_b), .i_global_clear_n(gcl_n),
        .i_global_clear_en(gce), .i_clear_n(clr_n),
        .i_cluster_clock_one(tk[3]), .i_cluster_clock_enable_one(tk[2]),
        .i_cluster_clock_two(tk[1]), .i_cluster_clock_enable_two(tk[0]),
        .i_cfg(lca_pkg::lca_cfg_t'(cfg)), .i_mode(mode), .i_ops(ops),
        .i_lut_mask(mask), .i_preset(pre), .i_clear_sel(csel),
        .i_carry_in_upper(nl[3]), .i_carry_in_lower(nl[2]),
        .i_shared_in_upper(nl[1]), .i_shared_in_lower(nl[0]),
        .i_reg_chain_in(rin), .o_carry_out_upper(lk[4]),
        .o_carry_out_lower(lk[3]), .o_shared_out_upper(lk[2]),
        .o_shared_out_lower(lk[1]), .o_final_carry(lk[0]),
        .o_reg_chain_out(cho), .o_upper_q(up), .o_lower_q(lo),
        .o_comb(comb), .o_lut_reg_q(lutq));

    // ==========================================================
    // reference model and helpers
    function automatic logic mj(logic a, logic b, logic c);
        return (a & b) | (c & (a ^ b));
    endfunction : mj
    function automatic lca_pkg::lca_ops_t [9:0] ops_of(int r);
        lca_pkg::lca_ops_t [9:0] o;
        for (int i = 0; i < 10; i++) begin
            o[i].x = 2'(r + i);
            o[i].y = 2'(3 * r + 2 * i + 1);
            o[i].z = 2'(r ^ i);
        end
        return o;
    endfunction : ops_of
    function automatic lca_exp_t calc(int r, lca_pkg::lca_mode_t m,
                                      lca_pkg::lca_cfg_t g, logic [3:0] li);
        lca_pkg::lca_ops_t [9:0] o;
        lca_exp_t                e;
        logic [9:0]              co, so;
        logic                    c, s, a, b;
        o = ops_of(r);
        co = '0;
        so = '0;
        for (int i = 0; i < 10; i++) begin
            c = (i == 0) ? (!g.carry_start_first & li[3]) : co[(i + 9) % 10];
            s = (i == 0) ? (!g.shared_start_first & li[1]) : so[(i + 9) % 10];
            if (i == 4) c = !g.carry_start_fifth & co[3];
            if (i == 5) c = g.carry_split ? li[2] : co[4];
            if (i == 5) s = !g.shared_start_sixth & (g.shared_split ? li[0] : so[4]);
            if (m != lca_pkg::LCA_MODE_ARITH && m != lca_pkg::LCA_MODE_SHARED) c = 1'b0;
            for (int k = 0; k < 2; k++) begin
                a = (m == lca_pkg::LCA_MODE_ARITH) ? o[i].x[k] : 1'b0;
                b = (m == lca_pkg::LCA_MODE_ARITH) ? o[i].y[k] : 1'b0;
                if (m == lca_pkg::LCA_MODE_SHARED) begin
                    a = o[i].x[k] ^ o[i].y[k] ^ o[i].z[k];
                    b = k ? mj(o[i].x[0], o[i].y[0], o[i].z[0]) : s;
                end
                if (k == 0) e.up[i] = a ^ b ^ c;
                else e.lo[i] = a ^ b ^ c;
                c = mj(a, b, c);
            end
            co[i] = c;
            so[i] = (m == lca_pkg::LCA_MODE_SHARED) & mj(o[i].x[1], o[i].y[1], o[i].z[1]);
        end
        e.lk[4] = !g.carry_split ? co[9] : (g.carry_bypass & BT ? li[3] : co[4]);
        e.lk[3] = g.carry_split & (g.carry_bypass & !BT ? li[2] : co[9]);
        e.lk[2] = !g.shared_split ? so[9] : (g.shared_bypass & BT ? li[1] : so[4]);
        e.lk[1] = g.shared_split & (g.shared_bypass & !BT ? li[0] : so[9]);
        e.lk[0] = (g.carry_split & g.carry_bypass & !BT) ? co[4] : co[9];
        return e;
    endfunction : calc
    task automatic add(lca_pkg::lca_mode_t m, logic [9:0] g, logic [3:0] li);
        rows.push_back(lca_row_t'{m, g, li, calc(rows.size(), m, lca_pkg::lca_cfg_t'(g), li)});
    endtask : add
    task automatic set_mode(lca_pkg::lca_mode_t m);
        foreach (mode[i]) mode[i] = m;
    endtask : set_mode
    task automatic step();
        @(posedge clk);
        #10;
    endtask : step
    task automatic chk(logic [47:0] got, logic [47:0] exp);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic conclude();
        if (err_count == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude

    // ==========================================================
    // clock, timeout and sequence
    always #50 clk = ~clk;
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            conclude();
        end
    end
    initial begin
        set_mode(lca_pkg::LCA_MODE_OFF);
        repeat (8) @(posedge clk);
        #10 rst_b = 1'b1;
        chk(48'({lk, cho, up, lo, comb, lutq}), 48'h0);
        add(lca_pkg::LCA_MODE_ARITH, 10'h000, 4'b1000);
        add(lca_pkg::LCA_MODE_ARITH, 10'h100, 4'b1000);
        add(lca_pkg::LCA_MODE_ARITH, 10'h180, 4'b1100);
        add(lca_pkg::LCA_MODE_ARITH, 10'h200, 4'b1100);
        add(lca_pkg::LCA_MODE_ARITH, 10'h240, 4'b1100);
        add(lca_pkg::LCA_MODE_OFF, 10'h000, 4'b1111);
        add(lca_pkg::LCA_MODE_SHARED, 10'h000, 4'b0010);
        add(lca_pkg::LCA_MODE_SHARED, 10'h018, 4'b0011);
        add(lca_pkg::LCA_MODE_SHARED, 10'h024, 4'b0011);
        add(lca_pkg::LCA_MODE_SHARED, 10'h020, 4'b0001);
        foreach (rows[n]) begin
            nin = rows[n].li;
            load = 1'b1;
            step();
            load = 1'b0;
            set_mode(rows[n].m);
            ops = ops_of(n);
            cfg = rows[n].g;
            tk = 4'hf;
            step();
            chk(48'({up, lo, lk}), 48'(rows[n].e));
        end
        sh = rows[$].e.up;
        lo_e = rows[$].e.lo;
        set_mode(lca_pkg::LCA_MODE_NORMAL);
        ops = ops_of(7);
        for (int i = 0; i < 10; i++) cx[i] = mask[{ops[i].x[1], ops[i].y[1], ops[i].x[0], ops[i].y[0]}];
        cfg = 10'h003;
        tk = 4'hc;
        for (int j = 0; j < 12; j++) begin
            rin = j[0] ^ j[2];
            step();
            sh = {sh[8:0], rin};
            chk(48'({cho, up}), 48'({sh[9], sh}));
            chk(48'(comb), 48'(cx));
            chk(48'(lutq), 48'(cx));
        end
        tk = 4'h8;
        rin = ~rin;
        repeat (3) step();
        chk(48'({up, lo, lutq}), 48'({sh, lo_e, cx}));
        for (int q = 0; q < 2; q++) begin
            clr_n = q ? 2'b01 : 2'b10;
            sm = q ? csel : ~csel;
            step();
            sh = (sh & ~sm) | (pre & sm);
            lo_e = (lo_e & ~sm) | (pre & sm);
            cx = cx & ~sm;
            chk(48'({up, lo, lutq}), 48'({sh, lo_e, cx}));
        end
        clr_n = 2'b11;
        gcl_n = 1'b0;
        step();
        chk(48'(up), 48'(sh));
        gce = 1'b1;
        tk = 4'hf;
        clr_n = 2'b00;
        step();
        chk(48'({up, lo, lutq, lk}), 48'({pre, pre, 10'h000, 5'h00}));
        gce = 1'b0;
        gcl_n = 1'b1;
        step();
        rst_b = 1'b0;
        #10 chk(48'({lk, cho, up, lo, comb, lutq}), 48'h0);
        conclude();
    end
endmodule : lca_cluster_tb
`default_nettype wire
